//--- src/pwc_pkg.sv
// Purpose: Constants and types for the powerdown wake controller
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes: Rules follow below
// Operation
// [RULE1] Powerdown needs request bit set, then halt
// [RULE2] Only interrupt or reset ends powerdown
// [RULE3] Interrupt wake waits on timing pin
// [RULE4] Reset wake skips the timing pin delay
// [RULE5] Timing pin push-pull, capacitor sets delay; the code only drives it low, then releases it
// [RULE6] Interrupt pulse latched, never lost
// [RULE7] Clocks stopped, state kept while powered down
package pwc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    // Discharge time before releasing the capacitor to charge
    localparam int DISCHARGE_NS = 100;
    localparam int DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] DISCHARGE_CNT = CNT_W'(DISCHARGE_CYC);
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [3:0] {
        PWC_RUN = 4'h1,
        PWC_DOWN = 4'h2,
        PWC_DISCH = 4'h4,
        PWC_CHARGE = 4'h8
    } pwc_state_e;

    typedef struct packed {
        pwc_state_e state;
        logic [CNT_W-1:0] cnt;
        logic wake_pend;
        logic clk_en;
        logic pd_active;
        logic nmi_req;
        logic tmr_o;
        logic tmr_oe;
        logic nmi_s1;
        logic nmi_s2;
        logic tmr_s1;
        logic tmr_s2;
    } pwc_regs_s;

    localparam pwc_regs_s PWC_RESET = '{
        state: PWC_RUN, cnt: CNT_RESET, wake_pend: 1'b0, clk_en: 1'b1,
        pd_active: 1'b0, nmi_req: 1'b0, tmr_o: 1'b0, tmr_oe: 1'b0,
        nmi_s1: 1'b0, nmi_s2: 1'b0, tmr_s1: 1'b0, tmr_s2: 1'b0
    };

endpackage : pwc_pkg

//--- src/pwc_wake_ctrl.sv
// Purpose: Enters powerdown on request plus halt, wakes on interrupt or reset
// Assumes: Reset input already synchronous; nmi and timing pin are async
// Notes: Timing pin discharged low, then released; wake when it reads high
`timescale 1ns/100ps
`default_nettype none
module pwc_wake_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic powerdown_request_bit,
    input wire logic halt_exec,
    input wire logic nmi,
    input wire logic nmi_ack,
    input wire logic pdtmr_in,
    output logic pdtmr_out,
    output logic pdtmr_oe,
    output logic clk_enable,
    output logic powerdown_active,
    output logic nmi_request
);
    import pwc_pkg::*;

    pwc_regs_s r;
    pwc_regs_s next_r;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.nmi_s1 = nmi;
        next_r.nmi_s2 = r.nmi_s1;
        next_r.tmr_s1 = pdtmr_in;
        next_r.tmr_s2 = r.tmr_s1;
        // Set beats acknowledge so a pulse in the ack cycle survives
        if (r.nmi_s2) begin
            next_r.nmi_req = 1'b1; // [RULE6]
            next_r.wake_pend = r.state != PWC_RUN; // [RULE6]
        end else if (nmi_ack) begin
            next_r.nmi_req = 1'b0;
        end
        unique case (r.state)
            PWC_RUN: begin
                next_r.tmr_oe = 1'b0;
                if (powerdown_request_bit && halt_exec) begin
                    next_r.state = PWC_DOWN; // [RULE1]
                    next_r.clk_en = 1'b0; // [RULE7]
                    next_r.pd_active = 1'b1;
                    next_r.wake_pend = 1'b0;
                end
            end
            PWC_DOWN: begin
                // Clocks held off, registers other than the synchronizers and nmi_req untouched until interrupt [RULE7]
                if (r.wake_pend || r.nmi_s2) begin
                    next_r.state = PWC_DISCH; // [RULE2]
                    next_r.cnt = CNT_RESET;
                    next_r.tmr_o = 1'b0;
                    next_r.tmr_oe = 1'b1; // [RULE5]
                end
            end
            PWC_DISCH: begin
                // Drains the capacitor so every delay starts from empty
                if (r.cnt == DISCHARGE_CNT - 8'h01) begin
                    next_r.state = PWC_CHARGE;
                    next_r.tmr_oe = 1'b0; // [RULE5]
                end else begin
                    next_r.cnt = r.cnt + 8'h01;
                end
            end
            PWC_CHARGE: begin
                // Delay length is set by the board capacitor plus the two-flop pin synchronizer
                if (r.tmr_s2) begin
                    next_r.state = PWC_RUN; // [RULE3]
                    next_r.clk_en = 1'b1; // [RULE3]
                    next_r.pd_active = 1'b0;
                    next_r.wake_pend = 1'b0;
                end
            end
            default: begin
                next_r = PWC_RESET;
            end
        endcase
        // Reset wake returns to run at once, no pin delay [RULE4]
        if (rst) begin
            next_r = PWC_RESET; // [RULE4]
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pdtmr_out = r.tmr_o;
    assign pdtmr_oe = r.tmr_oe;
    assign clk_enable = r.clk_en;
    assign powerdown_active = r.pd_active;
    assign nmi_request = r.nmi_req;

endmodule : pwc_wake_ctrl
`default_nettype wire

//--- bench/pwc_wake_ctrl_assertions.sv
// Purpose: wake checks. Assumes: sync rst. Notes: bound to pwc_wake_ctrl
`timescale 1ns/100ps
`default_nettype none
module pwc_chk (input wire logic clk, rst, powerdown_request_bit, halt_exec, nmi, nmi_ack,
    pdtmr_in, pdtmr_out, pdtmr_oe, clk_enable, powerdown_active, nmi_request);
default clocking @(posedge clk); endclocking
default disable iff (rst);
property p_in; halt_exec && powerdown_request_bit |=> powerdown_active; endproperty
a_in: assert property (p_in) else $error("entry");
property p_hd; powerdown_active && !nmi_request |=> !clk_enable; endproperty
a_hd: assert property (p_hd) else $error("hold");
property p_lt; $rose(nmi) |-> ##[1:3] nmi_request; endproperty
a_lt: assert property (p_lt) else $error("latch");
property p_dc; $rose(nmi_request) && powerdown_active |=> pdtmr_oe && !pdtmr_out; endproperty
a_dc: assert property (p_dc) else $error("drive");
property p_oe; $rose(pdtmr_oe) |-> ##24 pdtmr_oe ##1 !pdtmr_oe && !clk_enable; endproperty
a_oe: assert property (p_oe) else $error("delay");
property p_wk; $rose(pdtmr_in) && powerdown_active |-> !clk_enable ##[1:3] clk_enable; endproperty
a_wk: assert property (p_wk) else $error("wake");
property p_rs; disable iff (1'b0) rst |=> clk_enable && !powerdown_active; endproperty
a_rs: assert property (p_rs) else $error("reset");
cover property (halt_exec && powerdown_request_bit);
cover property ($rose(pdtmr_oe));
cover property (rst && powerdown_active);
endmodule : pwc_chk
bind pwc_wake_ctrl pwc_chk u_chk (.*);
`default_nettype wire

//--- bench/pwc_cap_model.sv
// Purpose: timing capacitor. Assumes: CHG cycles to charge. Notes: low while driven
`timescale 1ns/100ps
`default_nettype none
module pwc_cap_model #(parameter int CHG = 12) (input wire logic clk, pdtmr_oe, pdtmr_out,
    output logic pdtmr_in);
int lvl = CHG;
always @(posedge clk) lvl <= pdtmr_oe ? 0 : lvl + (lvl < CHG);
assign pdtmr_in = pdtmr_oe ? pdtmr_out : lvl >= CHG;
endmodule : pwc_cap_model
`default_nettype wire

//--- bench/pwc_wake_ctrl_tb.sv
// Purpose: wake bench. Assumes: cap model. Notes: drives at falling edge
`timescale 1ns/100ps
`default_nettype none
module pwc_wake_ctrl_tb;
logic clk = 0, rst = 1, powerdown_request_bit = 0, halt_exec = 0, nmi = 0, nmi_ack = 0;
logic pdtmr_in, pdtmr_out, pdtmr_oe, clk_enable, powerdown_active, nmi_request;
int n_mismatch = 0, n_tests = 0, i;
always #2 clk = ~clk;
pwc_wake_ctrl uut (.*);
pwc_cap_model cap (.*);
task automatic chk(logic s, e);
    n_tests++;
    if (s !== e) begin n_mismatch++; $display("BAD %0t %h %h", $time, s, e); end
endtask : chk
task automatic conclude;
    $display("tests %0d bad %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask : conclude
task automatic enter(logic b);
    powerdown_request_bit = b; halt_exec = 1;
    @(negedge clk) halt_exec = 0;
endtask : enter
task automatic t_nmi;
    enter(0); chk(powerdown_active, 0);
    enter(1); repeat (40) @(negedge clk); chk(clk_enable, 0);
    nmi = 1; @(negedge clk) nmi = 0;
    repeat (4) @(negedge clk);
    chk(pdtmr_oe, 1);
    chk(pdtmr_out, 0);
    chk(clk_enable, 0);
    for (i = 0; i < 200 && clk_enable !== 1; i++) @(negedge clk);
    if (i == 200) begin n_mismatch++; conclude(); end
    chk(i > 36, 1);
    chk(nmi_request, 1);
    chk(powerdown_active, 0);
    nmi_ack = 1; @(negedge clk) nmi_ack = 0;
    chk(nmi_request, 0);
    $display("nmi wake end");
endtask : t_nmi
task automatic t_rst;
    enter(1); chk(clk_enable, 0);
    rst = 1; @(negedge clk) rst = 0; chk(clk_enable, 1);
    chk(powerdown_active, 0);
    chk(pdtmr_oe, 0);
    $display("reset wake end");
endtask : t_rst
initial begin repeat (4) @(negedge clk); rst = 0; t_nmi(); t_rst(); conclude(); end
endmodule : pwc_wake_ctrl_tb
`default_nettype wire
